// [apo_output_path.sv]
// Digital output path of a nine-stage pipelined converter
`timescale 1ns/100ps
`default_nettype none
module apo_output_path (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [apo_pkg::NUM_STAGES*apo_pkg::STAGE_BITS-1:0] stageCodes,
  input wire logic floatOutputs,
  input wire logic rxReady,
  output logic [apo_pkg::WORD_BITS-1:0] dataOut,
  output logic dataValid,
  output logic dataOeN,
  output logic overrun
);

  apo_pkg::apo_core_s q;
  apo_pkg::apo_core_s d;
  logic [apo_pkg::NUM_STAGES-1:0][apo_pkg::STAGE_BITS-1:0] rawCode;
  logic [apo_pkg::NUM_STAGES-2:0][apo_pkg::STAGE_BITS-1:0] fixCode;
  apo_pkg::apo_word_t weighted [apo_pkg::NUM_STAGES-1];
  apo_pkg::apo_word_t corrWord;
  logic fillDone;
  logic bufReady;
  logic wordLost;

  // ==========================================================================
  // Stage alignment taps
  // Stage k of a sample arrives k/2 cycles after its start edge, two stages
  // per clock cycle; the tap depth makes all of them meet together.
  genvar k;
  for (k = 0; k < apo_pkg::NUM_STAGES - 1; k++) begin : g_stage
    localparam int unsigned TAP = apo_pkg::ALIGN_DEPTH - 1 - k / 2;
    assign rawCode[k] = q.align[k][TAP];
    // Overrange decision of a redundant stage is folded onto the top code
    assign fixCode[k] = (rawCode[k] > apo_pkg::CODE_TOP) ?
                        apo_pkg::CODE_TOP : rawCode[k];
    assign weighted[k] = apo_pkg::apo_word_t'(fixCode[k])
                         << (apo_pkg::NUM_STAGES - 1 - k);
  end
  // Final flash stage needs no delay; its word is registered downstream
  assign rawCode[apo_pkg::NUM_STAGES-1] =
    stageCodes[apo_pkg::NUM_STAGES*apo_pkg::STAGE_BITS-1 -: 2];

  // ==========================================================================
  // Error correction
  // Weights overlap by one bit, so any stage error is absorbed by the
  // following stages and the sum spans every code from zero to full scale.
  always_comb begin
    corrWord = apo_pkg::apo_word_t'(rawCode[apo_pkg::NUM_STAGES-1]);
    for (int i = 0; i < apo_pkg::NUM_STAGES - 1; i++) begin
      corrWord = corrWord + weighted[i];
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    // Each stage is captured on the rising edge; the held code moves one tap
    // deeper on each later rising edge, so nothing is shifted in the low phase.
    for (int i = 0; i < apo_pkg::NUM_STAGES - 1; i++) begin
      d.align[i] = {q.align[i][apo_pkg::ALIGN_DEPTH-2:0],
                    stageCodes[2*i +: 2]};
    end
    if (q.fill != apo_pkg::FILL_DONE) begin
      d.fill = q.fill + 3'h1;
    end
    d.oeN = floatOutputs;
    // Converter cannot pause; a word with no room is lost and flagged
    if (wordLost) begin
      d.overrun = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= apo_pkg::CORE_RESET;
    end else begin
      q <= d;
    end
  end

  assign fillDone = (q.fill == apo_pkg::FILL_DONE);
  assign wordLost = fillDone && !bufReady;

  // ==========================================================================
  // Output buffer
  // Word enters the head flop on the fourth edge after its start edge and
  // then stands for the whole cycle, ready for a falling-edge capture.
  apo_skid_buffer u_buffer (
    .clock(clock),
    .rstn(rstn),
    .inData(corrWord),
    .inValid(fillDone),
    .inReady(bufReady),
    .outData(dataOut),
    .outValid(dataValid),
    .outReady(rxReady)
  );

  assign dataOeN = q.oeN;
  assign overrun = q.overrun;

  // ==========================================================================
  // Checks
  AST_FIRST_WORD: assert property (@(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> !dataValid [*6] ##1 dataValid)
    else $error("first word not valid five cycles after start");

  AST_ALL_ZERO: assert property (@(posedge clock) disable iff (!rstn)
    (rawCode == 18'h00000) |-> (corrWord == apo_pkg::WORD_RESET))
    else $error("negative full scale is not all zeros");

  AST_ALL_ONES: assert property (@(posedge clock) disable iff (!rstn)
    (rawCode == 18'h3AAAA) |-> (corrWord == apo_pkg::WORD_FULL))
    else $error("positive full scale is not all ones");

  AST_FLOAT: assert property (@(posedge clock) disable iff (!rstn)
    floatOutputs |=> dataOeN)
    else $error("outputs drive while float requested");

  AST_DRIVE: assert property (@(posedge clock) disable iff (!rstn)
    !floatOutputs ##1 !floatOutputs |-> !dataOeN)
    else $error("outputs float while float input is low");

  AST_LAST_STAGE: assert property (@(posedge clock) disable iff (!rstn)
    (rawCode == 18'h30000) |-> (corrWord == 10'h003))
    else $error("final stage bits not in the low positions");

  AST_ALIGN: assert property (@(posedge clock) disable iff (!rstn)
    fillDone |-> (rawCode[0] == $past(stageCodes[1:0], 4)))
    else $error("first stage bits misaligned");

  AST_OVERRANGE: assert property (@(posedge clock) disable iff (!rstn)
    (rawCode[0] == 2'h3) |-> (corrWord >= apo_pkg::WORD_MID))
    else $error("overrange first stage lost the upper half");

  AST_MIDPOINT: assert property (@(posedge clock) disable iff (!rstn)
    (rawCode == 18'h25555) |-> (corrWord == apo_pkg::WORD_MID))
    else $error("midpoint word is not the top bit alone");

  AST_LOST_STICKY: assert property (@(posedge clock) disable iff (!rstn)
    wordLost |=> overrun [*2])
    else $error("lost word not flagged");

  AST_RESET_STATE: assert property (@(posedge clock)
    !rstn
      |=> !dataOeN && !dataValid && !overrun)
    else $error("reset left pins floating or a word pending");

  AST_OE_FOLLOW: assert property (@(posedge clock) disable iff (!rstn)
    1'b1
      |=> (dataOeN == $past(floatOutputs)))
    else $error("output enable did not follow float input");

  AST_HEAD_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    dataValid && !rxReady
      |=> dataValid && $stable(dataOut))
    else $error("stalled word did not stand");

  AST_FILL_VALID: assert property (@(posedge clock) disable iff (!rstn)
    fillDone
      |=> dataValid)
    else $error("no word after pipeline filled");

  AST_FILL_STEP: assert property (@(posedge clock) disable iff (!rstn)
    !fillDone
      |=> (q.fill == $past(q.fill) + 3'h1))
    else $error("fill count did not advance");

  AST_FILL_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    fillDone
      |=> fillDone)
    else $error("filled pipeline reported empty");

  AST_LOW_HALF: assert property (@(posedge clock) disable iff (!rstn)
    rawCode[0] == 2'h0
      |-> corrWord < apo_pkg::WORD_MID)
    else $error("lowest first stage code reached upper half");

  AST_STAGE0_ONE: assert property (@(posedge clock) disable iff (!rstn)
    rawCode[0] == 2'h1
      |-> (corrWord >= 10'h100) && (corrWord < 10'h300))
    else $error("middle first stage code out of its span");

  AST_STAGE0_TWO: assert property (@(posedge clock) disable iff (!rstn)
    rawCode[0] == 2'h2
      |-> corrWord >= apo_pkg::WORD_MID)
    else $error("top first stage code fell below midpoint");

  AST_ALIGN_TWO: assert property (@(posedge clock) disable iff (!rstn)
    fillDone
      |-> (rawCode[2] == $past(stageCodes[5:4], 3)))
    else $error("third stage bits misaligned");

  AST_ALIGN_FOUR: assert property (@(posedge clock) disable iff (!rstn)
    fillDone
      |-> (rawCode[4] == $past(stageCodes[9:8], 2)))
    else $error("fifth stage bits misaligned");

  AST_ALIGN_SEVEN: assert property (@(posedge clock) disable iff (!rstn)
    fillDone
      |-> (rawCode[7] == $past(stageCodes[15:14])))
    else $error("eighth stage bits misaligned");

  AST_LAST_ONLY: assert property (@(posedge clock) disable iff (!rstn)
    rawCode[apo_pkg::NUM_STAGES-2:0] == 16'h0000
      |-> corrWord == apo_pkg::apo_word_t'(rawCode[8]))
    else $error("final stage alone does not give its own code");

  AST_LOST_CAUSE: assert property (@(posedge clock) disable iff (!rstn)
    wordLost
      |-> dataValid && !rxReady)
    else $error("word lost while receiver was taking words");

  AST_OVR_CAUSE: assert property (@(posedge clock) disable iff (!rstn)
    $rose(overrun)
      |-> $past(wordLost))
    else $error("overrun set without a lost word");

endmodule
`default_nettype wire

// [apo_output_path_bench.sv]
// Self-checking bench for the converter output path
`timescale 1ns/100ps
`default_nettype none
module apo_output_path_bench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [17:0] stageCodes = 18'h00000;
  logic floatOutputs = 1'b0;
  logic [1:0] mode = 2'h0;
  logic rxReady;
  apo_pkg::apo_word_t dataOut;
  logic dataValid;
  logic dataOeN;
  logic overrun;
  apo_pkg::apo_word_t rxWord;
  int failures = 0;
  int samplesChecked = 0;
  int n = 0;
  logic [31:0] lfsr = 32'hDC3B5AC3;
  logic [17:0] codes [int];
  int q [$];
  logic ovExp = 1'b0;

  always #20 clock = ~clock;

  apo_output_path uut (.clock(clock), .rstn(rstn), .stageCodes(stageCodes),
    .floatOutputs(floatOutputs), .rxReady(rxReady), .dataOut(dataOut),
    .dataValid(dataValid), .dataOeN(dataOeN), .overrun(overrun));
  apo_rx_model rx (.clock(clock), .mode(mode), .dataValid(dataValid),
    .dataOut(dataOut), .rxReady(rxReady), .lastWord(rxWord));

  // ==========================================================================
  // Reference model
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // Overrange code 3 of the coarse stages counts as 2
  function automatic int wordOf(input logic [17:0] c);
    int w = int'(c[17:16]);
    for (int k = 0; k < 8; k++) begin
      w += int'(c[2*k+1 -: 2] == 2'h3 ? 2'h2 : c[2*k+1 -: 2]) << (8 - k);
    end
    return w;
  endfunction

  task automatic checkWord(input apo_pkg::apo_word_t got, exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkFlag(input logic got, exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s is %b expected %b", $time, what, got, exp);
    end
  endtask

  // One cycle: settle the model on the edge just past, compare, drive
  task automatic cycle(input logic [17:0] fresh, input logic fl);
    logic [17:0] drive;
    @(negedge clock);
    if (rxReady && q.size() > 0) begin
      checkWord(rxWord, 10'(q.pop_front()));
    end
    if (n >= 5) begin
      if (q.size() < 2) q.push_back(wordOf(codes[n - 5]));
      else ovExp = 1'b1;
    end
    checkFlag(dataValid, q.size() > 0, "valid");
    if (q.size() > 0) checkWord(dataOut, 10'(q[0]));
    checkFlag(overrun, ovExp, "overrun");
    checkFlag(dataOeN, floatOutputs, "float");
    codes[n] = fresh;
    // Each stage lags its elder pair by one cycle
    for (int k = 0; k < 9; k++) begin
      drive[2*k+1 -: 2] = n >= k/2 ? codes[n - k/2][2*k+1 -: 2] : 2'h0;
    end
    stageCodes <= drive;
    floatOutputs <= fl;
    n++;
  endtask

  task automatic run(input int count, input logic fl);
    repeat (count) begin
      lfsr = step(lfsr);
      cycle(lfsr[17:0], fl);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    cycle(18'h00000, 1'b0);
    cycle(18'h25555, 1'b0);
    cycle(18'h3AAAA, 1'b0);
    cycle(18'h3FFFF, 1'b0);
    run(40, 1'b0);
    run(4, 1'b1);
    run(10, 1'b0);
    mode <= 2'h1;
    run(40, 1'b0);
    mode <= 2'h2;
    run(6, 1'b0);
    mode <= 2'h0;
    run(12, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// [apo_pkg.sv]
// Constants and state types for the pipelined converter output path
package apo_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int unsigned NUM_STAGES = 9;
  localparam int unsigned STAGE_BITS = 2;
  localparam int unsigned WORD_BITS = 10;
  localparam int unsigned LATENCY = 5;
  localparam int unsigned ALIGN_DEPTH = 4;
  localparam real CLK_PERIOD_NS = 40.0;

  // ==========================================================================
  // Codes and reset values
  localparam logic [STAGE_BITS-1:0] CODE_TOP = 2'h2;
  localparam logic [WORD_BITS-1:0] WORD_MID = 10'h200;
  localparam logic [WORD_BITS-1:0] WORD_FULL = 10'h3FF;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 10'h000;
  localparam logic [2:0] FILL_RESET = 3'h0;
  localparam logic [2:0] FILL_DONE = 3'(LATENCY);
  localparam logic OE_DRIVE = 1'b0;

  typedef logic [WORD_BITS-1:0] apo_word_t;
  typedef logic [STAGE_BITS-1:0] apo_code_t;

  typedef struct packed {
    apo_word_t headData;
    logic headValid;
    apo_word_t skidData;
    logic skidValid;
  } apo_buf_s;

  typedef struct packed {
    logic [NUM_STAGES-2:0][ALIGN_DEPTH-1:0][STAGE_BITS-1:0] align;
    logic [2:0] fill;
    logic oeN;
    logic overrun;
  } apo_core_s;

  localparam apo_buf_s BUF_RESET = '{headData: WORD_RESET, headValid: 1'b0,
                                     skidData: WORD_RESET, skidValid: 1'b0};
  localparam apo_core_s CORE_RESET = '{align: '0, fill: FILL_RESET,
                                       oeN: OE_DRIVE, overrun: 1'b0};

endpackage

// [apo_rx_model.sv]
// Receiving logic model: paces the buffer and captures words
`timescale 1ns/100ps
`default_nettype none
module apo_rx_model (
  input wire logic clock,
  input wire logic [1:0] mode,
  input wire logic dataValid,
  input wire apo_pkg::apo_word_t dataOut,
  output logic rxReady,
  output var apo_pkg::apo_word_t lastWord
);
  logic [2:0] phase = 3'h0;
  logic nextReady;
  initial rxReady = 1'b1;
  // Mode 0 always ready, 1 stalls one cycle in eight, 2 stalls outright
  // A standing word is taken only if ready will be high at the next rise
  always @(negedge clock) begin
    nextReady = mode == 2'h0 || (mode == 2'h1 && phase != 3'h3);
    if (dataValid === 1'b1 && nextReady) begin
      lastWord <= dataOut;
    end
    phase <= phase + 3'h1;
    rxReady <= nextReady;
  end
endmodule
`default_nettype wire

// [apo_skid_buffer.sv]
// Two-entry buffer with registered head between converter and receiver
`timescale 1ns/100ps
`default_nettype none
module apo_skid_buffer (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [apo_pkg::WORD_BITS-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [apo_pkg::WORD_BITS-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  apo_pkg::apo_buf_s q;
  apo_pkg::apo_buf_s d;

  // ==========================================================================
  // Next state
  // Head is a flop so the pins never see a mux; skid absorbs one stall cycle
  always_comb begin
    d = q;
    if (!q.headValid || outReady) begin
      if (q.skidValid) begin
        d.headData = q.skidData;
        d.headValid = 1'b1;
        d.skidData = inData;
        d.skidValid = inValid;
      end else begin
        d.headData = inData;
        d.headValid = inValid;
      end
    end else if (inValid && !q.skidValid) begin
      d.skidData = inData;
      d.skidValid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= apo_pkg::BUF_RESET;
    end else begin
      q <= d;
    end
  end

  assign inReady = !q.skidValid || outReady;
  assign outData = q.headData;
  assign outValid = q.headValid;

  // ==========================================================================
  // Checks
  AST_HEAD_LOAD: assert property (@(posedge clock) disable iff (!rstn)
    (!q.skidValid && (!q.headValid || outReady))
      |=> (outData == $past(inData)) && (outValid == $past(inValid)))
    else $error("head did not take the incoming word");

endmodule
`default_nettype wire
